//--- shared/uart_status_map.svh
`ifndef UART_STATUS_MAP_SVH
`define UART_STATUS_MAP_SVH

// Byte offsets of the registers on the Avalon-MM slave (word aligned).
`define OFS_DATA        8'h00
`define OFS_IRQ_ENABLE  8'h04
`define OFS_MODEM_CTRL  8'h10
`define OFS_LINE_STATUS 8'h14
`define OFS_MODEM_STAT  8'h18
`define OFS_SCRATCH     8'h1c

// Modem control field positions.
`define MC_TERM_READY   0
`define MC_REQ_SEND     1
`define MC_RING_LOOP    2
`define MC_IRQ_DRIVE    3
`define MC_LOOPBACK     4
`define MC_POWER_DOWN   7
`define MC_WRITE_MASK   8'h9f

// Interrupt enable field positions.
`define IE_RX_DATA      0
`define IE_TX_EMPTY     1
`define IE_LINE_STATUS  2
`define IE_MODEM_STAT   3
`define IE_POWER_DOWN   5

// Line status field positions.
`define LS_DATA_READY   0
`define LS_OVERRUN      1
`define LS_PARITY       2
`define LS_FRAMING      3
`define LS_BREAK        4
`define LS_TX_HOLD_MT   5
`define LS_TX_ALL_MT    6
`define LS_FIFO_ERR     7

// Reset values and sizes.
`define RST_BYTE        8'h00
`define RX_DEPTH_DEF    16
`define TX_DEPTH_DEF    16

`endif

//--- shared/uart_status_pkg.sv
`default_nettype none
package uart_status_pkg;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_s;

  // Avalon-MM answer of the slave.
  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } av_rsp_s;

  // Modem inputs, all active low.
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic phone_call_indicator_n;
    logic carrier_detect_n;
  } modem_in_s;

  // Modem outputs, active low.
  typedef struct packed {
    logic dtr_n;
    logic rts_n;
  } modem_out_s;

  // One received character with its error flags.
  typedef struct packed {
    logic [7:0] data;
    logic       parity_err;
    logic       framing_err;
    logic       break_seen;
  } rx_char_s;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_phase_e;

endpackage
`default_nettype wire

//--- core/uart_line_modem_status.sv
// Summary of operation
// (R1) Control bit 3 drives irq pin; loop carrier
// (R2) Control bit 4 selects local loopback
// (R3) Power down needs control 7 and enable 5
// (R4) Data ready while receive store nonempty
// (R5) Full store: flag overrun, drop character
// (R6) Parity flag follows head character
// (R7) Framing flag follows head character
// (R8) Break flag; one break character per break
// (R9) Holding empty sets on drain, clears on load
// (R10) Holding empty with enable raises interrupt
// (R11) Transmit empty needs holding and shifter empty
// (R12) Error summary set by errors, read clears
// (R13) Change bits set on change, clear on read
// (R14) Ring change on trailing edge only
// (R15) Any change bit raises modem interrupt
// (R16) Levels are inverted modem inputs normally
// (R17) Loopback levels come from control bits
// (R18) Scratch byte stores eight bits
// (R19) Control bits 5 and 6 stay zero
// (R20) Control bits 0,1 drive ready, request low
// (R21) Loopback routes serial internally, pins idle
//
// Implementation choices: register access over Avalon-MM and the address map.
`include "uart_status_map.svh"
`default_nettype none
module uart_line_modem_status #(
  parameter int RX_DEPTH = `RX_DEPTH_DEF,
  parameter int TX_DEPTH = `TX_DEPTH_DEF
) (
  input  wire logic                        core_clk,        // System clock.
  input  wire logic                        rst_n,           // Synchronous reset, low.
  input  wire uart_status_pkg::av_req_s    av_req,          // Avalon request.
  output var  uart_status_pkg::av_rsp_s    av_rsp,          // Avalon answer.
  input  wire logic                        fifo_mode,       // FIFO mode select.
  input  wire logic                        rx_push,         // Receiver character done.
  input  wire uart_status_pkg::rx_char_s   rx_char,         // Received character.
  input  wire logic                        tx_take,         // Shifter takes a character.
  input  wire logic                        tx_shifter_busy, // Shifter holds a character.
  input  wire logic                        tx_serial_in,    // Serial bit from shifter.
  output logic [7:0]                       tx_data,         // Head transmit character.
  output logic                             tx_valid,        // Transmit store nonempty.
  output logic                             tx_pin,          // Serial output pin.
  input  wire logic                        rx_pin,          // Serial input pin.
  output logic                             rx_line,         // Serial line to receiver.
  input  wire uart_status_pkg::modem_in_s  modem_in,        // Modem input pins.
  output var  uart_status_pkg::modem_out_s modem_out,       // Modem output pins.
  output logic                             int_o,           // Interrupt level, high.
  output logic                             int_oe,          // Interrupt pin drive enable.
  output logic                             power_down       // Power down request.
);

  localparam int RX_AW = $clog2(RX_DEPTH);
  localparam int TX_AW = $clog2(TX_DEPTH);
  localparam logic [RX_AW:0] RX_FULL = (RX_AW + 1)'(RX_DEPTH);
  localparam logic [TX_AW:0] TX_FULL = (TX_AW + 1)'(TX_DEPTH);

  // Depths must be powers of two so the pointers wrap on their own.
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_rx_chk
    $error("RX_DEPTH must be a power of two of at least 2.");
  end
  if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin : g_tx_chk
    $error("TX_DEPTH must be a power of two of at least 2.");
  end

  typedef struct packed {
    uart_status_pkg::bus_phase_e                      phase;
    uart_status_pkg::av_rsp_s                         rsp;
    logic [7:0]                                       modem_control_reg;
    logic [7:0]                                       irq_enable_reg;
    logic [7:0]                                       scratch;
    logic [RX_DEPTH-1:0][$bits(uart_status_pkg::rx_char_s)-1:0] rx_mem;
    logic [RX_AW-1:0]                                 rx_rd;
    logic [RX_AW-1:0]                                 rx_wr;
    logic [RX_AW:0]                                   rx_cnt;
    logic [TX_DEPTH-1:0][7:0]                         tx_mem;
    logic [TX_AW-1:0]                                 tx_rd;
    logic [TX_AW-1:0]                                 tx_wr;
    logic [TX_AW:0]                                   tx_cnt;
    logic                                             overrun;
    logic                                             err_sum;
    logic                                             break_hold;
    logic [3:0]                                       delta;
    logic [3:0]                                       lvl_prev;
    logic                                             primed;
    logic [4:0]                                       meta;
    logic [4:0]                                       sync;
    logic [7:0]                                       tx_data;
    logic                                             tx_valid;
    logic                                             tx_pin;
    logic                                             rx_line;
    uart_status_pkg::modem_out_s                      mout;
    logic                                             int_o;
    logic                                             int_oe;
    logic                                             power_down;
  } st_s;

  st_s s_ff;
  st_s nxt_s;

  // Next state of the whole block.
  always_comb begin
    logic                      loop;
    logic [3:0]                lvl;
    logic [3:0]                chg;
    logic                      acc;
    logic                      wr;
    logic                      rd;
    logic                      hit_data;
    logic [7:0]                rbyte;
    logic [7:0]                line_status_reg;
    logic [RX_AW:0]            rx_lim;
    logic [TX_AW:0]            tx_lim;
    logic                      rx_ok;
    logic                      rx_pop;
    logic                      tx_ok;
    logic                      tx_pop;
    logic                      line_high;
    uart_status_pkg::rx_char_s head;
    uart_status_pkg::rx_char_s nhead;
    nxt_s     = s_ff;
    loop      = 1'b0;
    lvl       = 4'h0;
    chg       = 4'h0;
    rbyte     = 8'h00;
    line_status_reg       = 8'h00;
    rx_ok     = 1'b0;
    tx_ok     = 1'b0;
    head      = s_ff.rx_mem[s_ff.rx_rd];
    nhead     = head;
    acc       = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    hit_data  = 1'b0;
    rx_lim    = '0;
    tx_lim    = '0;
    rx_pop    = 1'b0;
    tx_pop    = 1'b0;
    line_high = 1'b1;

    // Pins pass two flip-flops; only the second stage is read.
    nxt_s.meta = {modem_in, rx_pin};
    nxt_s.sync = s_ff.meta;

    loop = s_ff.modem_control_reg[`MC_LOOPBACK]; // R2
    // Modem levels, bit 0 clear-to-send up to bit 3 carrier detect.
    if (loop) begin
      lvl = {s_ff.modem_control_reg[`MC_IRQ_DRIVE], s_ff.modem_control_reg[`MC_RING_LOOP],
             s_ff.modem_control_reg[`MC_TERM_READY], s_ff.modem_control_reg[`MC_REQ_SEND]}; // R17 R1
    end else begin
      lvl = ~{s_ff.sync[1], s_ff.sync[2], s_ff.sync[3], s_ff.sync[4]}; // R16
    end
    nxt_s.lvl_prev = lvl;
    nxt_s.primed   = 1'b1;
    // Ring counts only when its low pin returns high.
    if (s_ff.primed) begin
      chg    = lvl ^ s_ff.lvl_prev; // R14
      chg[2] = s_ff.lvl_prev[2] & ~lvl[2]; // R14
    end

    // Bus decode; a request is served once, then the slave idles a cycle.
    acc      = (s_ff.phase == uart_status_pkg::BUS_IDLE) & (av_req.read ^ av_req.write);
    wr       = acc & av_req.write & av_req.byteenable[0];
    rd       = acc & av_req.read;
    hit_data = ({av_req.address[7:2], 2'b00} == `OFS_DATA);

    rx_lim = fifo_mode ? RX_FULL : (RX_AW + 1)'(1);
    tx_lim = fifo_mode ? TX_FULL : (TX_AW + 1)'(1);

    // Line status as seen by software.
    line_status_reg[`LS_DATA_READY] = (s_ff.rx_cnt != '0); // R4
    line_status_reg[`LS_OVERRUN]    = s_ff.overrun;
    line_status_reg[`LS_PARITY]     = line_status_reg[`LS_DATA_READY] & head.parity_err; // R6
    line_status_reg[`LS_FRAMING]    = line_status_reg[`LS_DATA_READY] & head.framing_err; // R7
    line_status_reg[`LS_BREAK]      = line_status_reg[`LS_DATA_READY] & head.break_seen; // R8
    line_status_reg[`LS_TX_HOLD_MT] = (s_ff.tx_cnt == '0); // R9
    line_status_reg[`LS_TX_ALL_MT]  = (s_ff.tx_cnt == '0) & ~tx_shifter_busy; // R11
    line_status_reg[`LS_FIFO_ERR]   = fifo_mode & s_ff.err_sum; // R12

    // Read data mux; unmapped offsets read zero.
    unique case ({av_req.address[7:2], 2'b00})
      `OFS_DATA:        rbyte = head.data;
      `OFS_IRQ_ENABLE:  rbyte = s_ff.irq_enable_reg;
      `OFS_MODEM_CTRL:  rbyte = s_ff.modem_control_reg;
      `OFS_LINE_STATUS: rbyte = line_status_reg;
      `OFS_MODEM_STAT:  rbyte = {lvl, s_ff.delta};
      `OFS_SCRATCH:     rbyte = s_ff.scratch; // R18
      default:          rbyte = 8'h00;
    endcase

    // Answer phase: waitrequest low for exactly one cycle.
    if (acc) begin
      nxt_s.phase           = uart_status_pkg::BUS_ANSWER;
      nxt_s.rsp.waitrequest = 1'b0;
      nxt_s.rsp.readdata    = rd ? {24'h000000, rbyte} : 32'h00000000;
    end else begin
      nxt_s.phase           = uart_status_pkg::BUS_IDLE;
      nxt_s.rsp.waitrequest = 1'b1;
    end

    // Register writes.
    if (wr) begin
      unique case ({av_req.address[7:2], 2'b00})
        `OFS_IRQ_ENABLE: nxt_s.irq_enable_reg = av_req.writedata[7:0];
        `OFS_MODEM_CTRL: nxt_s.modem_control_reg = av_req.writedata[7:0] & `MC_WRITE_MASK; // R19
        `OFS_SCRATCH:    nxt_s.scratch = av_req.writedata[7:0]; // R18
        default:         nxt_s.scratch = s_ff.scratch;
      endcase
    end

    // Change bits: a change in the read cycle survives the clear.
    nxt_s.delta = ((rd && {av_req.address[7:2], 2'b00} == `OFS_MODEM_STAT) ?
                   4'h0 : s_ff.delta) | chg; // R13

    // Receive store; one break character per break, overrun drops it.
    line_high        = loop ? s_ff.rx_line : s_ff.sync[0];
    // Overrun: a status read clears it, an arrival into a full store sets it; the set wins.
    if (rd && {av_req.address[7:2], 2'b00} == `OFS_LINE_STATUS) begin
      nxt_s.overrun = 1'b0;
    end
    if (rx_push && !(rx_char.break_seen && s_ff.break_hold)) begin // R8
      if (s_ff.rx_cnt >= rx_lim) begin
        nxt_s.overrun = 1'b1; // R5
      end else begin
        rx_ok = 1'b1;
      end
    end
    nxt_s.break_hold = (s_ff.break_hold & ~line_high) |
                       (rx_push & rx_char.break_seen); // R8
    rx_pop = rd & hit_data & (s_ff.rx_cnt != '0);
    if (rx_ok) begin
      nxt_s.rx_mem[s_ff.rx_wr] = rx_char;
      nxt_s.rx_wr = s_ff.rx_wr + 1'b1;
    end
    if (rx_pop) begin
      nxt_s.rx_rd = s_ff.rx_rd + 1'b1;
    end
    nxt_s.rx_cnt = s_ff.rx_cnt + (RX_AW + 1)'(rx_ok) - (RX_AW + 1)'(rx_pop);
    // Error summary: set by an errored arrival, cleared by a data read.
    nxt_s.err_sum = ((rd & hit_data) ? 1'b0 : s_ff.err_sum) |
                    (rx_ok & (rx_char.parity_err | rx_char.framing_err |
                              rx_char.break_seen)); // R12

    // Transmit store; a write clears holding empty, draining sets it.
    tx_ok  = wr & hit_data & (s_ff.tx_cnt < tx_lim); // R9
    tx_pop = tx_take & (s_ff.tx_cnt != '0); // R9
    if (tx_ok) begin
      nxt_s.tx_mem[s_ff.tx_wr] = av_req.writedata[7:0];
      nxt_s.tx_wr = s_ff.tx_wr + 1'b1;
    end
    if (tx_pop) begin
      nxt_s.tx_rd = s_ff.tx_rd + 1'b1;
    end
    nxt_s.tx_cnt = s_ff.tx_cnt + (TX_AW + 1)'(tx_ok) - (TX_AW + 1)'(tx_pop);

    // Registered outputs, formed from the next state.
    nhead          = nxt_s.rx_mem[nxt_s.rx_rd];
    nxt_s.tx_data  = nxt_s.tx_mem[nxt_s.tx_rd];
    nxt_s.tx_valid = (nxt_s.tx_cnt != '0);
    nxt_s.tx_pin   = nxt_s.modem_control_reg[`MC_LOOPBACK] | tx_serial_in; // R21
    nxt_s.rx_line  = nxt_s.modem_control_reg[`MC_LOOPBACK] ? tx_serial_in : s_ff.sync[0]; // R21
    nxt_s.mout.dtr_n = nxt_s.modem_control_reg[`MC_LOOPBACK] | ~nxt_s.modem_control_reg[`MC_TERM_READY]; // R20 R21
    nxt_s.mout.rts_n = nxt_s.modem_control_reg[`MC_LOOPBACK] | ~nxt_s.modem_control_reg[`MC_REQ_SEND]; // R20 R21
    nxt_s.int_oe   = nxt_s.modem_control_reg[`MC_IRQ_DRIVE]; // R1
    nxt_s.int_o    =
      (nxt_s.irq_enable_reg[`IE_RX_DATA] & (nxt_s.rx_cnt != '0)) |
      (nxt_s.irq_enable_reg[`IE_TX_EMPTY] & (nxt_s.tx_cnt == '0)) | // R10
      (nxt_s.irq_enable_reg[`IE_LINE_STATUS] & (nxt_s.overrun |
        ((nxt_s.rx_cnt != '0) & (nhead.parity_err | nhead.framing_err |
                                 nhead.break_seen)))) |
      (nxt_s.irq_enable_reg[`IE_MODEM_STAT] & (|nxt_s.delta)); // R15
    nxt_s.power_down = nxt_s.modem_control_reg[`MC_POWER_DOWN] & nxt_s.irq_enable_reg[`IE_POWER_DOWN]; // R3
  end

  // State register with synchronous reset to idle pin levels.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_ff                 <= '0;
      s_ff.rsp.waitrequest <= 1'b1;
      s_ff.meta            <= 5'h1f;
      s_ff.sync            <= 5'h1f;
      s_ff.tx_pin          <= 1'b1;
      s_ff.rx_line         <= 1'b1;
      s_ff.mout            <= 2'h3;
      s_ff.int_o           <= 1'b0;
      s_ff.modem_control_reg             <= `RST_BYTE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign av_rsp     = s_ff.rsp;
  assign tx_data    = s_ff.tx_data;
  assign tx_valid   = s_ff.tx_valid;
  assign tx_pin     = s_ff.tx_pin;
  assign rx_line    = s_ff.rx_line;
  assign modem_out  = s_ff.mout;
  assign int_o      = s_ff.int_o;
  assign int_oe     = s_ff.int_oe;
  assign power_down = s_ff.power_down;

endmodule
`default_nettype wire

//--- bench/uart_lms_checker_assertions.sv
`include "uart_status_map.svh"
`default_nettype none
module uart_lms_checker (
  input wire logic                        core_clk,     // Clock.
  input wire logic                        rst_n,        // Reset, low.
  input wire uart_status_pkg::av_req_s    av_req,       // Bus request.
  input wire uart_status_pkg::av_rsp_s    av_rsp,       // Bus answer.
  input wire logic                        tx_serial_in, // Shifter bit.
  input wire logic                        tx_pin,       // Serial out.
  input wire logic                        rx_line,      // Receiver line.
  input wire uart_status_pkg::modem_in_s  modem_in,     // Modem pins.
  input wire uart_status_pkg::modem_out_s modem_out,    // Modem outputs.
  input wire logic                        int_oe,       // Interrupt drive.
  input wire logic                        power_down    // Power down.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_ff, ier_ff, scr_ff, adr_ff;
  logic [2:0] qc_ff, ms_ff;
  logic       rd_ff, take, wr, quiet, ans, lp;
  // Bus request taken, answer seen, and settled state after writes.
  assign take  = (av_req.read ^ av_req.write) & av_rsp.waitrequest;
  assign wr    = take & av_req.write & av_req.byteenable[0];
  assign quiet = qc_ff == 3'h3;
  assign ans   = !av_rsp.waitrequest & rd_ff;
  assign lp    = ctl_ff[4];
  // Shadows of the written registers and counters of settled cycles.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_ff <= 8'h00;
      ier_ff <= 8'h00;
      scr_ff <= 8'h00;
      adr_ff <= 8'h00;
      rd_ff  <= 1'b0;
      qc_ff  <= 3'h0;
      ms_ff  <= 3'h0;
    end else begin
      qc_ff <= wr ? 3'h0 : qc_ff + 3'(!quiet);
      ms_ff <= !$stable(modem_in) ? 3'h0 : ms_ff + 3'(ms_ff != 3'h7);
      if (take) adr_ff <= av_req.address;
      if (take) rd_ff <= av_req.read;
      if (wr && av_req.address == `OFS_MODEM_CTRL) ctl_ff <= av_req.writedata[7:0] & 8'h9f;
      if (wr && av_req.address == `OFS_IRQ_ENABLE) ier_ff <= av_req.writedata[7:0];
      if (wr && av_req.address == `OFS_SCRATCH) scr_ff <= av_req.writedata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_oe_follows_ctl: assert property (quiet |-> int_oe == ctl_ff[3])
    else $error("interrupt drive enable differs from control");
  a_loop_pins_idle: assert property (quiet && lp |-> tx_pin && modem_out == 2'h3)
    else $error("outputs not idle in loopback");
  a_tx_pass_thru: assert property (quiet && !lp |-> tx_pin == $past(tx_serial_in))
    else $error("serial out does not follow shifter");
  a_rx_loop_route: assert property (quiet && lp |-> rx_line == $past(tx_serial_in))
    else $error("loopback line does not follow shifter");
  a_power_gate: assert property (quiet |-> power_down == (ctl_ff[7] & ier_ff[5]))
    else $error("power down gating wrong");
  a_drive_levels: assert property (quiet && !lp |-> modem_out == {~ctl_ff[0], ~ctl_ff[1]})
    else $error("modem outputs differ from control");
  a_pin_levels: assert property (ans && quiet && !lp && ms_ff == 3'h7 &&
    adr_ff == `OFS_MODEM_STAT |-> av_rsp.readdata[7:4] == ~{modem_in.carrier_detect_n,
    modem_in.phone_call_indicator_n, modem_in.dsr_n, modem_in.cts_n})
    else $error("modem levels differ from pins");
  a_loop_levels: assert property (ans && quiet && lp && adr_ff == `OFS_MODEM_STAT |->
    av_rsp.readdata[7:4] == {ctl_ff[3], ctl_ff[2], ctl_ff[0], ctl_ff[1]})
    else $error("loopback levels differ from control");
  a_scratch_back: assert property (ans && adr_ff == `OFS_SCRATCH |->
    av_rsp.readdata == {24'h0, scr_ff}) else $error("scratch read back wrong");
  a_ctl_back: assert property (ans && adr_ff == `OFS_MODEM_CTRL |->
    av_rsp.readdata == {24'h0, ctl_ff}) else $error("control read back wrong");
  c_loop_read: cover property (ans && lp && adr_ff == `OFS_MODEM_STAT);
  c_power_down: cover property (power_down);
  c_back_to_back: cover property (ans ##1 take);
endmodule
`default_nettype wire

//--- bench/modem_peer.sv
`default_nettype none
module modem_peer (
  input  wire logic                   core_clk, // Clock.
  input  wire logic [3:0]             lvl,      // Pin levels to show.
  input  wire logic                   brk,      // Hold the line low.
  input  wire logic                   hold,     // Stall the shifter.
  input  wire logic                   tx_valid, // Store nonempty.
  input  wire logic [7:0]             tx_data,  // Head character.
  output uart_status_pkg::modem_in_s  modem_in, // Modem pins.
  output logic                        rx_pin,   // Serial line in.
  output logic                        tx_take,  // Take pulse.
  output logic                        tx_busy,  // Shifter loaded.
  output logic                        tx_ser    // Shifter bit.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh  = 8'hff;
  // Pins idle high; the shifter sends idle mark when empty.
  assign modem_in = uart_status_pkg::modem_in_s'(lvl);
  assign rx_pin   = ~brk;
  assign tx_busy  = cnt != 4'h0;
  assign tx_ser   = tx_busy ? sh[0] : 1'b1;
  // Take one character, then stay busy for nine cycles.
  always @(posedge core_clk) begin
    tx_take <= 1'b0;
    if (tx_busy) begin
      cnt <= cnt - 4'h1;
      sh  <= {1'b1, sh[7:1]};
    end else if (tx_valid && !hold) begin
      tx_take <= 1'b1;
      sh      <= tx_data;
      cnt     <= 4'h9;
    end
  end
endmodule
`default_nettype wire

//--- bench/uart_line_modem_status_tb.sv
`include "uart_status_map.svh"
`default_nettype none
module uart_line_modem_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        core_clk = 1'b0;
  logic                        rst_n    = 1'b0;
  logic                        rx_push  = 1'b0;
  logic                        brk      = 1'b0;
  logic                        hold     = 1'b1;
  logic                        fifo_md  = 1'b1;
  logic [3:0]                  lvl      = 4'hf;
  uart_status_pkg::av_req_s    av_req   = '0;
  uart_status_pkg::rx_char_s   rx_char  = '0;
  uart_status_pkg::av_rsp_s    av_rsp;
  uart_status_pkg::modem_in_s  modem_in;
  uart_status_pkg::modem_out_s modem_out;
  uart_status_pkg::rx_char_s   ch, h, rxq[$];
  logic [7:0]                  tx_data, c, e, ex, txq[$];
  logic [31:0]                 rd;
  logic [3:0]                  chg;
  logic                        tx_take, tx_busy, tx_ser, tx_valid, tx_pin, rx_pin, rx_line;
  logic                        int_o, int_oe, power_down, ovr, sum, sup;
  int                          num_errors = 0;
  int                          checked    = 0;
  int                          seed       = 32'h0a2779a0;
  int                          n;
  initial forever #5 core_clk = ~core_clk;
  uart_line_modem_status #(.RX_DEPTH(4), .TX_DEPTH(4)) uart_line_modem_status_inst (
    .core_clk(core_clk), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp), .fifo_mode(fifo_md),
    .rx_push(rx_push), .rx_char(rx_char), .tx_take(tx_take), .tx_shifter_busy(tx_busy),
    .tx_serial_in(tx_ser), .tx_data(tx_data), .tx_valid(tx_valid), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .rx_line(rx_line), .modem_in(modem_in), .modem_out(modem_out),
    .int_o(int_o), .int_oe(int_oe), .power_down(power_down));
  modem_peer modem_peer_inst (.core_clk(core_clk), .lvl(lvl), .brk(brk), .hold(hold),
    .tx_valid(tx_valid), .tx_data(tx_data), .modem_in(modem_in), .rx_pin(rx_pin),
    .tx_take(tx_take), .tx_busy(tx_busy), .tx_ser(tx_ser));
  // Compare, count and report.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One Avalon-MM access, held until waitrequest is sampled low.
  task automatic bus(input logic rd_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    av_req <= '{rd_en, !rd_en, a, {24'h0, d}, 4'hf};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (av_rsp.waitrequest && n < 20);
    if (av_rsp.waitrequest) num_errors++;
    if (av_rsp.waitrequest) summarize();
    rd = av_rsp.readdata;
    av_req <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(1'b1, a, 8'h00);
    check(rd, x);
  endtask
  // Each character the shifter takes must be the next one written.
  always @(posedge core_clk) begin
    if (tx_take && txq.size() > 0) check({24'h0, tx_data}, {24'h0, txq.pop_front()});
  end
  initial begin
    ovr = 1'b0;
    sum = 1'b0;
    sup = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(`OFS_MODEM_CTRL, 32'h0);
    rdc(`OFS_LINE_STATUS, 32'h60);
    rdc(`OFS_MODEM_STAT, 32'h0);
    check(32'({int_oe, power_down, modem_out}), 32'h3);
    // Random control, enable and scratch values.
    for (int i = 0; i < 12; i++) begin
      c = 8'($random(seed));
      e = 8'($random(seed));
      bus(1'b0, `OFS_MODEM_CTRL, c);
      bus(1'b0, `OFS_IRQ_ENABLE, e);
      bus(1'b0, `OFS_SCRATCH, ~e);
      rdc(`OFS_SCRATCH, {24'h0, ~e});
      rdc(`OFS_MODEM_CTRL, {24'h0, c & 8'h9f});
      repeat (3) @(posedge core_clk);
      check(32'({int_oe, power_down}), 32'({c[3], c[7] & e[5]}));
      check(32'(modem_out), c[4] ? 32'h3 : 32'({~c[0], ~c[1]}));
      bus(1'b1, `OFS_MODEM_STAT, 8'h00);
      check(32'(rd[7:4]), c[4] ? 32'({c[3], c[2], c[0], c[1]}) : 32'h0);
    end
    // Each modem pin toggled twice, modem interrupt only.
    bus(1'b0, `OFS_MODEM_CTRL, 8'h00);
    bus(1'b0, `OFS_IRQ_ENABLE, 8'h08);
    repeat (8) @(posedge core_clk);
    bus(1'b1, `OFS_MODEM_STAT, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lvl[3 - i % 4] <= ~lvl[3 - i % 4];
      repeat (8) @(posedge core_clk);
      chg = (i % 4 == 2 && !lvl[1]) ? 4'h0 : 4'h1 << (i % 4);
      ex = {~lvl[0], ~lvl[1], ~lvl[2], ~lvl[3], chg};
      check(32'(int_o), 32'(chg != 4'h0));
      rdc(`OFS_MODEM_STAT, {24'h0, ex});
      rdc(`OFS_MODEM_STAT, {24'h0, ex[7:4], 4'h0});
    end
    repeat (2) @(posedge core_clk);
    check(32'(int_o), 32'h0);
    // Receive: errors, a repeated break and one character too many.
    bus(1'b0, `OFS_IRQ_ENABLE, 8'h00);
    for (int i = 0; i < 6; i++) begin
      brk <= (i == 2 || i == 3);
      repeat (5) @(posedge core_clk);
      check(32'(rx_line), 32'(!brk));
      ch = '{8'($random(seed)), i == 0, i == 1, i == 2 || i == 3};
      rx_char <= ch;
      rx_push <= 1'b1;
      @(posedge core_clk);
      rx_push <= 1'b0;
      if (!ch.break_seen) sup = 1'b0;
      if (rxq.size() == 4) ovr = 1'b1;
      else if (!(ch.break_seen && sup)) rxq.push_back(ch);
      if (rxq.size() < 4 || i < 5) sum |= ch.parity_err | ch.framing_err | ch.break_seen;
      if (ch.break_seen) sup = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      h = rxq.size() > 0 ? rxq[0] : '0;
      ex = {sum, 2'b11, h.break_seen, h.framing_err, h.parity_err, ovr, rxq.size() > 0};
      rdc(`OFS_LINE_STATUS, {24'h0, ex});
      ovr = 1'b0;
      if (rxq.size() > 0) rdc(`OFS_DATA, {24'h0, h.data});
      if (rxq.size() > 0) void'(rxq.pop_front());
      sum = 1'b0;
    end
    // Transmit: fill past full with the shifter stalled, then drain.
    bus(1'b0, `OFS_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge core_clk);
    check(32'(int_o), 32'h1);
    for (int i = 0; i < 5; i++) begin
      c = 8'($random(seed));
      bus(1'b0, `OFS_DATA, c);
      if (i < 4) txq.push_back(c);
    end
    rdc(`OFS_LINE_STATUS, 32'h0);
    check(32'(int_o), 32'h0);
    hold <= 1'b0;
    for (n = 0; n < 200 && tx_valid !== 1'b0; n++) @(posedge core_clk);
    if (tx_valid !== 1'b0) num_errors++;
    rdc(`OFS_LINE_STATUS, 32'h20);
    repeat (12) @(posedge core_clk);
    rdc(`OFS_LINE_STATUS, 32'h60);
    check(32'(txq.size()), 32'h0);
    // Character mode: a one-deep store, so the second arrival overruns; no summary bit.
    fifo_md <= 1'b0;
    rx_char <= '{8'h5a, 1'b1, 1'b0, 1'b0};
    rx_push <= 1'b1;
    repeat (2) @(posedge core_clk);
    rx_push <= 1'b0;
    rdc(`OFS_LINE_STATUS, 32'h67);
    rdc(`OFS_DATA, 32'h5a);
    rdc(`OFS_LINE_STATUS, 32'h60);
    summarize();
  end
endmodule
bind uart_line_modem_status uart_lms_checker uart_lms_checker_inst (.core_clk(core_clk),
  .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp), .tx_serial_in(tx_serial_in),
  .tx_pin(tx_pin), .rx_line(rx_line), .modem_in(modem_in), .modem_out(modem_out),
  .int_oe(int_oe), .power_down(power_down));
`default_nettype wire
